// *** rtl/uhet_pkg.sv ***
// Shared constants for the serial channel event-timing block.
// Assumes one 40 MHz reference clock and synchronous host strobes.
// Notes on behaviour
// - Non-FIFO: holding loads one baud tick later
// - Baud clock is sixteen times bit rate
// - FIFO mode: data readable with no delay
// - Receive interrupt within two clocks after stop
// - Transmit starts 8 to 24 baud ticks later
// - Receive DMA ready within one clock after stop
// - Transmit DMA ready drops within 16 ticks
// - Servicing read clears interrupt within 70 ns
// - Transmit write clears interrupt within 70 ns
// - Transmit write reasserts DMA ready, 70 ns
// - Modem input change raises interrupt, 70 ns
package uhet_pkg;
	localparam int CLK_PERIOD_NS   = 25;                          // Reference clock period
	localparam int HOST_RESP_NS    = 70;                          // Longest strobe-to-output time
	localparam int HOST_RESP_CYC   = (HOST_RESP_NS / CLK_PERIOD_NS < 1) ? 1 : HOST_RESP_NS / CLK_PERIOD_NS;
	localparam int OVERSAMPLE      = 16;                          // Baud ticks per bit
	localparam int RX_MID_TICK     = 7;                           // Tick of bit centre
	localparam int TX_START_MIN    = 8;                           // Least ticks before transmit
	localparam int TX_START_MAX    = 24;                          // Most ticks before transmit
	localparam int TX_START_TICKS  = 16;                          // Chosen start delay
	localparam int FRAME_BITS      = 10;                          // Start, eight data, stop
	localparam logic [2:0] ADDR_RX_HOLD  = 3'h0;                  // Receive holding read
	localparam logic [2:0] ADDR_TX_HOLD  = 3'h0;                  // Transmit holding write
	localparam logic [2:0] ADDR_IRQ_ID   = 3'h2;                  // Interrupt ident read
	localparam logic [2:0] ADDR_LINE_ST  = 3'h5;                  // Line state read
	localparam logic [2:0] ADDR_MODEM_ST = 3'h6;                  // Modem state read
	localparam int IRQ_RX          = 0;                           // Enable bit positions
	localparam int IRQ_TX          = 1;
	localparam int IRQ_MODEM       = 3;
	localparam logic [3:0] ID_NONE  = 4'h1;                       // Ident codes, bit 0 = none pending
	localparam logic [3:0] ID_RX    = 4'h4;
	localparam logic [3:0] ID_TX    = 4'h2;
	localparam logic [3:0] ID_MODEM = 4'h0;
	typedef enum logic [1:0] {UHET_RX_IDLE, UHET_RX_START, UHET_RX_BITS} uhet_rx_state_t;
endpackage

// *** rtl/uhet_top.sv ***
// One serial channel: baud divider, 8N1 receiver and transmitter, and the
// interrupt and DMA-ready event timing seen by the host strobe bus.
// Assumes host strobes and address are synchronous to i_ref_clk.
module uhet_top
	import uhet_pkg::*;
#(
	parameter int DIV_W = 16                                      // Divisor width
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_reset,
	input  wire logic [DIV_W-1:0] i_divisor,
	input  wire logic             i_fifo_mode,
	input  wire logic [3:0]       i_irq_enable,
	input  wire logic             i_host_read_strobe,
	input  wire logic             i_host_write_strobe,
	input  wire logic [2:0]       i_host_addr,
	input  wire logic [7:0]       i_host_wdata,
	input  wire logic             i_rx_serial,
	input  wire logic [3:0]       i_modem_status,
	output logic [7:0]            o_host_rdata,
	output logic                  o_irq,
	output logic                  o_rx_dma_ready,
	output logic                  o_tx_dma_ready,
	output logic                  o_tx_serial
);
	// Tick counter is served up to 16 bits; refuse anything else at elaboration
	if (DIV_W < 1 || DIV_W > 16) begin : g_div_w_bad
		$error("DIV_W must be 1..16");
	end

	// Baud divider; zero divisor treated as one
	logic [DIV_W-1:0] div_cnt_r;
	logic             baud_tick;
	assign baud_tick = (div_cnt_r == '0);
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || baud_tick) div_cnt_r <= (i_divisor == '0) ? '0 : i_divisor - 1'b1;
		else div_cnt_r <= div_cnt_r - 1'b1;
	end

	// Host strobe edges, one pulse per strobe
	logic rd_prev_r, wr_prev_r;
	logic rd_pulse, wr_pulse, rd_rx, rd_id, rd_modem, wr_tx;
	assign rd_pulse = i_host_read_strobe & ~rd_prev_r;
	assign wr_pulse = i_host_write_strobe & ~wr_prev_r;
	assign rd_rx    = rd_pulse && i_host_addr == ADDR_RX_HOLD;
	assign rd_id    = rd_pulse && i_host_addr == ADDR_IRQ_ID;
	assign rd_modem = rd_pulse && i_host_addr == ADDR_MODEM_ST;
	assign wr_tx    = wr_pulse && i_host_addr == ADDR_TX_HOLD;
	always_ff @(posedge i_ref_clk) begin
		rd_prev_r <= i_reset ? 1'b0 : i_host_read_strobe;
		wr_prev_r <= i_reset ? 1'b0 : i_host_write_strobe;
	end

	// Receiver: centre-sampled 8N1 on the 16x tick
	uhet_rx_state_t rx_state_r;
	logic [3:0]     rx_tick_r;                                    // Ticks within a bit
	logic [3:0]     rx_bit_r;                                     // Bits taken so far
	logic [7:0]     rx_shift_r;
	logic           rx_done;                                      // Stop bit sampled
	logic           rx_mid;
	assign rx_mid  = baud_tick && rx_tick_r == 4'(RX_MID_TICK);
	assign rx_done = rx_mid && rx_state_r == UHET_RX_BITS && rx_bit_r == 4'(FRAME_BITS - 2);
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rx_state_r <= UHET_RX_IDLE;
			rx_tick_r  <= 4'h0;
			rx_bit_r   <= 4'h0;
			rx_shift_r <= 8'h00;
		end else if (baud_tick) begin
			rx_tick_r <= rx_tick_r + 4'h1;
			case (rx_state_r)
				UHET_RX_IDLE: begin                                   // Wait for falling line
					rx_tick_r <= 4'h0;
					if (!i_rx_serial) rx_state_r <= UHET_RX_START;
				end
				UHET_RX_START: begin                                  // False start rejected at centre
					if (rx_mid) rx_state_r <= i_rx_serial ? UHET_RX_IDLE : UHET_RX_BITS;
					rx_bit_r <= 4'h0;
				end
				UHET_RX_BITS: begin
					if (rx_mid) begin
						if (rx_bit_r == 4'(FRAME_BITS - 2)) rx_state_r <= UHET_RX_IDLE;
						else rx_shift_r <= {i_rx_serial, rx_shift_r[7:1]};
						rx_bit_r <= rx_bit_r + 4'h1;
					end
				end
				default: rx_state_r <= UHET_RX_IDLE;
			endcase
		end
	end

	// Status and holding: status is set at once, the holding load may lag
	logic rx_avail_r, rx_load_pend_r, rx_pend_r;
	logic [7:0] rx_hold_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rx_avail_r     <= 1'b0;
			rx_load_pend_r <= 1'b0;
			rx_pend_r      <= 1'b0;
			rx_hold_r      <= 8'h00;
		end else begin
			// Set wins over a read in the same cycle
			rx_avail_r <= rx_done | (rx_avail_r & ~rd_rx);
			rx_pend_r  <= rx_done | (rx_pend_r & ~rd_rx);
			if (rx_done && i_fifo_mode) rx_hold_r <= rx_shift_r;
			else if (rx_load_pend_r && baud_tick) rx_hold_r <= rx_shift_r;
			// Reading before this lands returns the old byte; host must wait a tick
			rx_load_pend_r <= (rx_done && !i_fifo_mode) | (rx_load_pend_r & ~baud_tick);
		end
	end

	// Transmitter: holding byte, start delay, 9-bit shifter
	logic       tx_full_r, tx_busy_r, tx_pend_r, tx_dma_r, tx_line_r;
	logic [4:0] tx_wait_r;                                        // Ticks since waiting began
	logic [3:0] tx_tick_r, tx_bit_r;
	logic [7:0] tx_hold_r;
	logic [8:0] tx_shift_r;
	logic       tx_start;
	// A write in the start cycle restarts the wait, so no start, flag or DMA drop then
	assign tx_start = baud_tick && tx_full_r && !tx_busy_r && !wr_tx && tx_wait_r == 5'(TX_START_TICKS - 1);
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			tx_full_r <= 1'b0;
			tx_busy_r <= 1'b0;
			tx_wait_r <= 5'h00;
			tx_tick_r <= 4'h0;
			tx_bit_r  <= 4'h0;
			tx_hold_r <= 8'h00;
			tx_shift_r <= 9'h1ff;
			tx_line_r <= 1'b1;
		end else begin
			if (wr_tx) begin                                          // New byte restarts the wait
				tx_hold_r <= i_host_wdata;
				tx_full_r <= 1'b1;
				tx_wait_r <= 5'h00;
			end else if (tx_start) begin
				tx_full_r  <= 1'b0;
				tx_busy_r  <= 1'b1;
				tx_shift_r <= {1'b1, tx_hold_r};
				tx_line_r  <= 1'b0;
				tx_tick_r  <= 4'h0;
				tx_bit_r   <= 4'h0;
			end else if (baud_tick && tx_full_r && !tx_busy_r) tx_wait_r <= tx_wait_r + 5'h01;
			if (baud_tick && tx_busy_r) begin
				tx_tick_r <= tx_tick_r + 4'h1;
				if (tx_tick_r == 4'(OVERSAMPLE - 1)) begin           // Bit boundary
					tx_bit_r <= tx_bit_r + 4'h1;
					if (tx_bit_r == 4'(FRAME_BITS - 1)) tx_busy_r <= 1'b0;
					else begin
						tx_line_r  <= tx_shift_r[0];
						tx_shift_r <= {1'b1, tx_shift_r[8:1]};
					end
				end
			end
		end
	end

	// Transmit interrupt: event sets beat host clears; DMA ready: host write sets, transmit start clears
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			tx_pend_r <= 1'b0;
			tx_dma_r  <= 1'b1;
		end else begin
			tx_pend_r <= tx_start | (tx_pend_r & ~wr_tx & ~(rd_id && !rx_pend_r));
			tx_dma_r  <= wr_tx | (tx_dma_r & ~tx_start);
		end
	end

	// Modem change detection; first flop after reset captures without a change
	logic [3:0] modem_prev_r, modem_delta_r;
	logic       modem_seen_r, modem_change;
	assign modem_change = modem_seen_r && (i_modem_status != modem_prev_r);
	always_ff @(posedge i_ref_clk) begin
		modem_prev_r <= i_reset ? 4'h0 : i_modem_status;
		modem_seen_r <= ~i_reset;
		if (i_reset) modem_delta_r <= 4'h0;
		else modem_delta_r <= (modem_change ? (i_modem_status ^ modem_prev_r) : 4'h0)
			| (rd_modem ? 4'h0 : modem_delta_r);
	end

	// Priority ident and output registers
	logic [3:0] pend_vec, id_code;
	logic [7:0] rdata_nxt;
	assign pend_vec  = {|modem_delta_r, 1'b0, tx_pend_r, rx_pend_r} & i_irq_enable;
	assign id_code   = pend_vec[IRQ_RX] ? ID_RX : pend_vec[IRQ_TX] ? ID_TX
		: pend_vec[IRQ_MODEM] ? ID_MODEM : ID_NONE;
	assign rdata_nxt = (i_host_addr == ADDR_RX_HOLD)  ? rx_hold_r
		: (i_host_addr == ADDR_IRQ_ID)   ? {4'h0, id_code}
		: (i_host_addr == ADDR_LINE_ST)  ? {1'b0, ~tx_full_r & ~tx_busy_r, ~tx_full_r, 4'h0, rx_avail_r}
		: (i_host_addr == ADDR_MODEM_ST) ? {i_modem_status, modem_delta_r} : 8'h00;
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_host_rdata   <= 8'h00;
			o_irq          <= 1'b0;
			o_rx_dma_ready <= 1'b0;
			o_tx_dma_ready <= 1'b1;
			o_tx_serial    <= 1'b1;
		end else begin
			if (rd_pulse) o_host_rdata <= rdata_nxt;                  // Captured at strobe edge
			o_irq          <= |pend_vec;
			o_rx_dma_ready <= rx_done | (o_rx_dma_ready & ~rd_rx);
			o_tx_dma_ready <= tx_dma_r;
			o_tx_serial    <= tx_line_r;
		end
	end

	// Checks beside the logic
	localparam int RESP_CYC = HOST_RESP_CYC;                      // Strobe-to-output bound in clocks
	a_rx_irq_stop: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		rx_done && i_irq_enable[IRQ_RX] |-> ##[1:2] o_irq) else $error("rx irq late");
	a_rx_dma_stop: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		rx_done |=> o_rx_dma_ready) else $error("rx dma ready late");
	a_rx_hold_lag: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		rx_load_pend_r && baud_tick && !rx_done |=> rx_hold_r == $past(rx_shift_r)) else $error("hold not loaded");
	a_rx_hold_fifo: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		rx_done && i_fifo_mode |=> rx_hold_r == $past(rx_shift_r) && rx_avail_r) else $error("fifo load lag");
	a_tx_start_win: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		tx_start |-> tx_wait_r + 5'h01 >= 5'(TX_START_MIN) && tx_wait_r < 5'(TX_START_MAX)) else $error("tx start window");
	a_tx_dma_drop: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		tx_start && !wr_tx |-> ##2 !o_tx_dma_ready) else $error("tx dma not dropped");
	a_rd_clear_irq: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		rd_rx && !rx_done |=> !rx_pend_r) else $error("read did not clear");
	a_wr_clear_irq: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		wr_tx |=> !tx_pend_r) else $error("write did not clear");
	a_wr_dma_set: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		wr_tx |-> ##RESP_CYC o_tx_dma_ready) else $error("tx dma not set");
	a_modem_irq: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		modem_change && i_irq_enable[IRQ_MODEM] |-> ##2 o_irq) else $error("modem irq late");
	a_baud_div: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		baud_tick && i_divisor > 1 && $stable(i_divisor) |=> !baud_tick) else $error("tick too often");
endmodule

// *** sim/uhet_host.sv ***
// Host processor model driving the read and write strobes.
// Assumes the device samples strobes on the rising clock edge.
module uhet_host (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	output logic            o_rd,
	output logic            o_wr,
	output logic [2:0]      o_addr,
	output logic [7:0]      o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	parameter int DIV = 2;                 // Clocks per baud tick
	initial begin
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_addr = 3'h7;
		o_wdata = 8'h00;
	end
	// One read; strobe low one cycle after, address scrambled when released
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge i_clk) begin
			o_addr = a;
			o_rd = 1'b1;
		end
		@(negedge i_clk) begin
			o_rd = 1'b0;
			o_addr = ~a;
		end
		@(negedge i_clk) d = i_rdata;
	endtask
	// One write, same spacing as a read
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(negedge i_clk) begin
			o_addr = a;
			o_wdata = v;
			o_wr = 1'b1;
		end
		@(negedge i_clk) begin
			o_wr = 1'b0;
			o_addr = ~a;
			o_wdata = ~v;
		end
	endtask
	// Single-byte mode: holding may lag status, so wait one baud tick first
	task automatic rd_rx(output logic [7:0] d);
		repeat (DIV) @(negedge i_clk);
		rd(3'h0, d);
	endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for one serial channel's event timing.
// Assumes uhet_top and the host model; serial line driven here.
module testbench
	import uhet_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = 2;                // Small divisor keeps frames short
	localparam int BIT = OVERSAMPLE * DIV; // Clocks per serial bit
	logic       clk, rst, fifo, rxs, rd, wr, irq, rxr, txr, txs;
	logic [3:0] en, modem;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, d, b;
	int         bad_count, compares, n;
	logic [7:0] q[$];                      // Expected bytes in order

	uhet_top DUT (.i_ref_clk(clk), .i_reset(rst), .i_divisor(16'h0002), .i_fifo_mode(fifo),
		.i_irq_enable(en), .i_host_read_strobe(rd), .i_host_write_strobe(wr), .i_host_addr(addr),
		.i_host_wdata(wdata), .i_rx_serial(rxs), .i_modem_status(modem), .o_host_rdata(rdata),
		.o_irq(irq), .o_rx_dma_ready(rxr), .o_tx_dma_ready(txr), .o_tx_serial(txs));
	uhet_host #(.DIV(DIV)) H (.i_clk(clk), .i_rdata(rdata), .o_rd(rd), .o_wr(wr), .o_addr(addr),
		.o_wdata(wdata));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (e !== g) begin
			bad_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Elapsed cycles must fall inside a window
	task automatic chk_in(input int lo, input int hi, input int v);
		compares++;
		if (v < lo || v > hi) begin
			bad_count++;
			$display("MISMATCH t=%0t exp=%h..%h got=%h", $time, lo, hi, v);
		end
	endtask
	// Bounded wait for a level; n returns clocks spent
	task automatic wait_lv(ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask
	// Start, data, then stop left standing; then checks DMA ready, interrupt and the byte read
	task automatic rx_case(input logic fm);
		logic [9:0] f;
		b = 8'($urandom);
		q.push_back(b);
		fifo = fm;
		en = 4'h1;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxs = f[i];
			if (i < 9) repeat (BIT) @(negedge clk);
		end
		wait_lv(rxr, 1'b1, BIT);
		chk_in(1, BIT - 1, n);
		wait_lv(irq, 1'b1, 8);
		chk_in(0, DIV, n);
		if (fm) H.rd(ADDR_RX_HOLD, d);
		else begin
			H.rd(ADDR_LINE_ST, d);
			chk(8'h61, d);
			H.rd(ADDR_IRQ_ID, d);
			chk({4'h0, ID_RX}, d);
			H.rd_rx(d);
		end
		chk(q.pop_front(), d);
		@(negedge clk);
		chk(8'h00, {6'h0, irq, rxr});
	endtask
	task automatic conclude();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		fifo = 1'b0;
		en = 4'h0;
		rxs = 1'b1;
		modem = 4'h0;
		bad_count = 0;
		compares = 0;
		n = $urandom(32'h05d2);
		repeat (10) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk(8'h03, {6'h0, txr, txs});
		rx_case(1'b0);
		rx_case(1'b1);
		// Modem change: flag within three clocks, deltas show changed inputs
		en = 4'h8;
		b = {4'h0, modem ^ (4'($urandom) | 4'h1)};
		modem = b[3:0];
		wait_lv(irq, 1'b1, 8);
		chk_in(1, 3, n);
		H.rd(ADDR_MODEM_ST, d);
		chk({b[3:0], b[3:0]}, d);
		@(negedge clk);
		chk(8'h00, {7'h0, irq});
		// Two transmissions; second write also services the tx flag
		en = 4'h2;
		for (int k = 0; k < 2; k++) begin
			b = 8'($urandom);
			chk({7'h0, k[0]}, {7'h0, irq});
			H.wr(ADDR_TX_HOLD, b);
			@(negedge clk);
			chk(8'h01, {6'h0, irq, txr});
			wait_lv(txs, 1'b0, 30 * BIT);
			chk_in(TX_START_MIN * DIV, TX_START_MAX * DIV + 2, n + 1);
			repeat (BIT / 2) @(negedge clk);
			chk(8'h00, {6'h0, txr, txs});
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(negedge clk);
				d[i] = txs;
			end
			chk(b, d);
			repeat (BIT) @(negedge clk);
			chk(8'h01, {7'h0, txs});
			repeat (BIT) @(negedge clk);
		end
		// Ident read services the pending transmit flag
		H.rd(ADDR_LINE_ST, d);
		chk(8'h60, d);
		H.rd(ADDR_IRQ_ID, d);
		chk({4'h0, ID_TX}, d);
		@(negedge clk);
		chk(8'h00, {7'h0, irq});
		conclude();
	end
endmodule
